// File: general_register_bank.v
// sixteen 32-bit general registers with one write port
`timescale 1ns/100ps
`include "processor_state_defines.vh"
module general_register_bank #(
    parameter COUNT = `GREG_COUNT,
    parameter WIDTH = `GREG_WIDTH,
    parameter IDX_W = `GREG_IDX_W
) (
    input wire core_clk,
    input wire rst_n,
    input wire wrEn,
    input wire [IDX_W-1:0] wrIdx,
    input wire [WIDTH-1:0] wrData,
    input wire [WIDTH-1:0] wrMask,
    output wire [COUNT*WIDTH-1:0] allRegs
);
    reg [WIDTH-1:0] bank_reg [0:COUNT-1];
    genvar g;
    generate
        for (g = 0; g < COUNT; g = g + 1) begin : slot
            always @(posedge core_clk) begin
                if (!rst_n) begin
                    bank_reg[g] <= {WIDTH{1'b0}};
                end else if (wrEn && wrIdx == g) begin
                    bank_reg[g] <= (bank_reg[g] & ~wrMask) |
                        (wrData & wrMask);
                end
            end
            assign allRegs[g*WIDTH +: WIDTH] = bank_reg[g];
        end
    endgenerate
endmodule

// File: processor_state_defines.vh
// register offsets, field positions and reset values of the state block
`ifndef PROCESSOR_STATE_DEFINES_VH
`define PROCESSOR_STATE_DEFINES_VH
`define GREG_COUNT 16
`define GREG_WIDTH 32
`define GREG_IDX_W 4
`define GREG_ARG_BASE 4'hC
`define GREG_FRAME_BASE 4'hD
`define GREG_STACK_TOP 4'hE
`define GREG_NEXT_INSTR 4'hF
`define ADDR_GREG_LAST 8'h3C
`define ADDR_STATUS_LW 8'h40
`define STATUS_LW_RESET 32'h041F0000
`define STATUS_LW_WRITABLE 32'h4FDF00FF
`define STATUS_LW_LOW_HALF 32'h0000FFFF
`define SL_COMPAT 31
`define SL_TRACE_PEND 30
`define SL_FIRST_PART 27
`define SL_INT_STACK 26
`define SL_MODE_HI 25
`define SL_MODE_LO 24
`define SL_PREV_HI 23
`define SL_PREV_LO 22
`define SL_PRIO_HI 20
`define SL_PRIO_LO 16
`define SL_DEC_OV 7
`define SL_FLT_UF 6
`define SL_INT_OV 5
`define SL_TRACE 4
`define SL_CC_HI 3
`define SL_CC_LO 0
`define MODE_KERNEL 2'h0
`define ICR_DEPTH 64
`define ICR_IDX_W 6
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: processor_state_regs.v
// processor state: general registers, status longword, control regs
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "processor_state_defines.vh"
module processor_state_regs #(
    parameter ICR_DEPTH = `ICR_DEPTH,
    parameter ICR_IDX_W = `ICR_IDX_W
) (
    input wire core_clk,
    input wire rst_n,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire coreRegWrEn,
    input wire [3:0] coreRegWrIdx,
    input wire [31:0] coreRegWrData,
    input wire [3:0] coreRegRdIdx,
    output reg [31:0] coreRegRdData,
    input wire coreStatusWrEn,
    input wire [31:0] coreStatusWrData,
    input wire ccWrEn,
    input wire [3:0] ccWrData,
    output reg [31:0] statusLongword,
    output reg [31:0] nextInstrPointer,
    output reg [31:0] stackTopPointer,
    output reg [31:0] frameBasePointer,
    output reg [31:0] argBasePointer,
    input wire exceptionTaken,
    input wire contextSwitch,
    output reg statusSaveValid,
    output reg statusSaveToContext,
    output reg [31:0] statusSaveData,
    input wire icrReq,
    input wire icrWrite,
    input wire [ICR_IDX_W-1:0] icrIdx,
    input wire [31:0] icrWrData,
    output reg icrDone,
    output reg [31:0] icrRdData,
    output reg icrPrivFault,
    input wire integerOverflow,
    input wire floatUnderflow,
    output reg integerOverflowTrap,
    output reg floatUnderflowFault,
    output reg presentKernel
);
    // address decode results
    localparam SEL_GREG = 2'h0;
    localparam SEL_STATUS = 2'h1;
    localparam SEL_NONE = 2'h2;

    // byte strobes to a bit mask
    function [31:0] strobeMask;
        input [3:0] strb;
        integer k;
        begin
            for (k = 0; k < 4; k = k + 1) begin
                strobeMask[k*8 +: 8] = {8{strb[k]}};
            end
        end
    endfunction

    // word address decode: 0 greg, 1 status, 2 unmapped
    function [1:0] decodeAddr;
        input [7:0] addr;
        begin
            if (addr[1:0] != 2'h0) begin
                decodeAddr = SEL_NONE;
            end else if (addr <= `ADDR_GREG_LAST) begin
                decodeAddr = SEL_GREG;
            end else if (addr == `ADDR_STATUS_LW) begin
                decodeAddr = SEL_STATUS;
            end else begin
                decodeAddr = SEL_NONE;
            end
        end
    endfunction

    // one 32-bit word out of the flattened bank
    function [31:0] pickWord;
        input [`GREG_COUNT*32-1:0] regs;
        input [3:0] idx;
        begin
            pickWord = regs[idx*32 +: 32];
        end
    endfunction

    wire [`GREG_COUNT*32-1:0] allRegs;
    wire [31:0] statusValue;
    wire kernelMode;

    reg awHeld_reg;
    reg [7:0] awAddr_reg;
    reg wHeld_reg;
    reg [31:0] wData_reg;
    reg [3:0] wStrb_reg;
    reg [31:0] icrMem_reg [0:ICR_DEPTH-1];

    // bus write waits while the core writes the same storage
    wire [1:0] wrSel = decodeAddr(awAddr_reg);
    wire busWrBlocked = (wrSel == SEL_GREG && coreRegWrEn) ||
        (wrSel == SEL_STATUS && (coreStatusWrEn || ccWrEn));
    wire busWrGo = awHeld_reg && wHeld_reg && !s_axi_bvalid &&
        !busWrBlocked;
    wire busRegWr = busWrGo && wrSel == SEL_GREG;
    wire busStatusWr = busWrGo && wrSel == SEL_STATUS;
    // refused: hole, or privileged status bytes outside kernel mode
    wire busWrRefused = wrSel == SEL_NONE || (wrSel == SEL_STATUS &&
        !kernelMode && wStrb_reg[3:2] != 2'h0);

    wire gregWrEn = coreRegWrEn || busRegWr;
    wire [3:0] gregWrIdx = coreRegWrEn ? coreRegWrIdx : awAddr_reg[5:2];
    wire [31:0] gregWrData = coreRegWrEn ? coreRegWrData : wData_reg;
    wire [31:0] gregWrMask = coreRegWrEn ? 32'hFFFFFFFF :
        strobeMask(wStrb_reg);

    general_register_bank #(
        .COUNT(`GREG_COUNT),
        .WIDTH(`GREG_WIDTH),
        .IDX_W(`GREG_IDX_W)
    ) u_bank (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .wrEn(gregWrEn),
        .wrIdx(gregWrIdx),
        .wrData(gregWrData),
        .wrMask(gregWrMask),
        .allRegs(allRegs)
    );

    wire statusWrEn = coreStatusWrEn || busStatusWr;
    wire [31:0] statusWrData = coreStatusWrEn ? coreStatusWrData :
        wData_reg;
    wire [31:0] statusWrMask = coreStatusWrEn ? 32'hFFFFFFFF :
        strobeMask(wStrb_reg);

    status_longword_reg u_status (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .wrEn(statusWrEn),
        .wrData(statusWrData),
        .wrMask(statusWrMask),
        .ccEn(ccWrEn),
        .ccData(ccWrData),
        .kernelMode(kernelMode),
        .value(statusValue)
    );

    // registered copies of the dedicated pointers and status
    always @(posedge core_clk) begin
        if (!rst_n) begin
            coreRegRdData <= 32'h00000000;
            nextInstrPointer <= 32'h00000000;
            stackTopPointer <= 32'h00000000;
            frameBasePointer <= 32'h00000000;
            argBasePointer <= 32'h00000000;
            statusLongword <= `STATUS_LW_RESET;
            presentKernel <= 1'b1;
        end else begin
            coreRegRdData <= pickWord(allRegs, coreRegRdIdx);
            nextInstrPointer <=
                allRegs[`GREG_NEXT_INSTR*32 +: 32];
            stackTopPointer <=
                allRegs[`GREG_STACK_TOP*32 +: 32];
            frameBasePointer <=
                allRegs[`GREG_FRAME_BASE*32 +: 32];
            argBasePointer <=
                allRegs[`GREG_ARG_BASE*32 +: 32];
            statusLongword <= statusValue;
            presentKernel <= kernelMode;
        end
    end

    // an exception wins, so a joint request becomes a stack push
    wire saveReq = exceptionTaken || contextSwitch;
    wire saveToContext = contextSwitch && !exceptionTaken;

    // status save on exception push or context switch store
    always @(posedge core_clk) begin
        if (!rst_n) begin
            statusSaveValid <= 1'b0;
            statusSaveToContext <= 1'b0;
            statusSaveData <= 32'h00000000;
        end else begin
            statusSaveValid <= saveReq;
            if (saveReq) begin
                statusSaveToContext <= saveToContext;
                statusSaveData <= statusValue;
            end
        end
    end

    // arithmetic events gated by the status enables
    always @(posedge core_clk) begin
        if (!rst_n) begin
            integerOverflowTrap <= 1'b0;
            floatUnderflowFault <= 1'b0;
        end else begin
            integerOverflowTrap <= integerOverflow &&
                statusValue[`SL_INT_OV];
            floatUnderflowFault <= floatUnderflow &&
                statusValue[`SL_FLT_UF];
        end
    end

    // move instructions act only in kernel mode
    wire icrGranted = icrReq && kernelMode;
    wire icrRefused = icrReq && !kernelMode;

    // internal control registers, kernel-mode move instructions only
    always @(posedge core_clk) begin
        if (icrGranted && icrWrite) begin
            icrMem_reg[icrIdx] <= icrWrData;
        end
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            icrDone <= 1'b0;
            icrPrivFault <= 1'b0;
            icrRdData <= 32'h00000000;
        end else begin
            icrDone <= icrGranted;
            icrPrivFault <= icrRefused;
            if (icrGranted && !icrWrite) begin
                icrRdData <= icrMem_reg[icrIdx];
            end
        end
    end

    // each ready is a one-cycle offer, withheld while an answer waits
    wire awOffer = !awHeld_reg && !s_axi_awready && !s_axi_bvalid;
    wire wOffer = !wHeld_reg && !s_axi_wready && !s_axi_bvalid;

    // bus write channels: address and data taken in either order
    always @(posedge core_clk) begin
        if (!rst_n) begin
            awHeld_reg <= 1'b0;
            awAddr_reg <= 8'h00;
            wHeld_reg <= 1'b0;
            wData_reg <= 32'h00000000;
            wStrb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            s_axi_awready <= awOffer;
            s_axi_wready <= wOffer;
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_reg <= 1'b1;
                awAddr_reg <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_reg <= 1'b1;
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (busWrGo) begin
                awHeld_reg <= 1'b0;
                wHeld_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (busWrRefused) begin
                    s_axi_bresp <= `RESP_SLVERR;
                end else begin
                    s_axi_bresp <= `RESP_OKAY;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // bus read channel
    wire [1:0] rdSel = decodeAddr(s_axi_araddr);
    reg [31:0] rdWord;
    reg [1:0] rdResp;
    always @* begin
        rdWord = 32'h00000000;
        rdResp = `RESP_OKAY;
        case (rdSel)
            SEL_GREG: begin
                rdWord = pickWord(allRegs, s_axi_araddr[5:2]);
            end
            SEL_STATUS: begin
                rdWord = statusValue;
            end
            default: begin
                rdResp = `RESP_SLVERR;
            end
        endcase
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdWord;
                s_axi_rresp <= rdResp;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// File: processor_state_regs_properties.sv
// assertions on the ports of the processor state block
`timescale 1ns/100ps
module processor_state_regs_checker (
    input wire core_clk,
    input wire rst_n,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [1:0] s_axi_bresp,
    input wire [3:0] coreRegRdIdx,
    input wire [31:0] coreRegRdData,
    input wire [31:0] statusLongword,
    input wire [31:0] nextInstrPointer,
    input wire [31:0] stackTopPointer,
    input wire [31:0] frameBasePointer,
    input wire [31:0] argBasePointer,
    input wire exceptionTaken,
    input wire contextSwitch,
    input wire statusSaveValid,
    input wire statusSaveToContext,
    input wire icrReq,
    input wire icrDone,
    input wire icrPrivFault,
    input wire integerOverflow,
    input wire floatUnderflow,
    input wire integerOverflowTrap,
    input wire floatUnderflowFault,
    input wire presentKernel
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    sequence saveOut;
        ##[1:2] statusSaveValid;
    endsequence
    sequence pushOut;
        ##[1:2] (statusSaveValid && !statusSaveToContext);
    endsequence
    reset_value_a: assert property (rst_n && $past(!rst_n) |->
        statusLongword == 32'h041F0000 && presentKernel)
        else $error("status not at initial value");
    compat_zero_a: assert property (!statusLongword[31])
        else $error("compatibility bit set");
    mbz_zero_a: assert property (statusLongword[29:28] == 2'h0 &&
        !statusLongword[21] && statusLongword[15:8] == 8'h00)
        else $error("must-be-zero bits set");
    kernel_flag_a: assert property (
        presentKernel == (statusLongword[25:24] == 2'h0))
        else $error("kernel flag wrong");
    int_trap_a: assert property ($stable(statusLongword) |->
        integerOverflowTrap == ($past(integerOverflow) && statusLongword[5]))
        else $error("integer trap gating wrong");
    flt_fault_a: assert property ($stable(statusLongword) |->
        floatUnderflowFault == ($past(floatUnderflow) && statusLongword[6]))
        else $error("float fault gating wrong");
    save_pulse_a: assert property ((exceptionTaken || contextSwitch)
        |-> saveOut) else $error("status save missing");
    stack_push_a: assert property (exceptionTaken |-> pushOut)
        else $error("exception save not a push");
    icr_answer_a: assert property (icrReq |=> icrDone != icrPrivFault)
        else $error("control access unanswered");
    next_ptr_a: assert property (coreRegRdIdx == 4'hF |=>
        coreRegRdData == nextInstrPointer) else $error("pointer 15 wrong");
    stack_ptr_a: assert property (coreRegRdIdx == 4'hE |=>
        coreRegRdData == stackTopPointer) else $error("pointer 14 wrong");
    frame_ptr_a: assert property (coreRegRdIdx == 4'hD |=>
        coreRegRdData == frameBasePointer) else $error("pointer 13 wrong");
    arg_ptr_a: assert property (coreRegRdIdx == 4'hC |=>
        coreRegRdData == argBasePointer) else $error("pointer 12 wrong");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("response dropped");
endmodule
bind processor_state_regs processor_state_regs_checker i_chk (.*);

// File: processor_state_regs_tb_top.sv
// self-checking bench for the processor state block
`timescale 1ns/100ps
`include "processor_state_defines.vh"
module processor_state_regs_tb_top;
    reg core_clk = 1'h0, rst_n = 1'h0, coreRegWrEn = 1'h0;
    reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    reg s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, icrReq = 1'h0;
    reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    reg [31:0] s_axi_wdata = 32'h0, coreRegWrData = 32'h0, icrWrData = 32'h0;
    reg [31:0] coreStatusWrData = 32'h0;
    reg [3:0] s_axi_wstrb = 4'h0, coreRegWrIdx = 4'h0, coreRegRdIdx = 4'h0;
    reg [3:0] ccWrData = 4'h0;
    reg coreStatusWrEn = 1'h0, ccWrEn = 1'h0, icrWrite = 1'h0;
    reg exceptionTaken = 1'h0, contextSwitch = 1'h0;
    reg integerOverflow = 1'h0, floatUnderflow = 1'h0;
    reg [5:0] icrIdx = 6'h00;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, statusSaveValid, statusSaveToContext;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata, coreRegRdData, statusLongword, nextInstrPointer;
    wire [31:0] stackTopPointer, frameBasePointer, argBasePointer;
    wire [31:0] statusSaveData, icrRdData;
    wire icrDone, icrPrivFault, presentKernel;
    wire integerOverflowTrap, floatUnderflowFault;
    integer mismatches = 0, check_count = 0, cycles = 0, i;
    reg [31:0] d;
    reg [1:0] r;
    processor_state_regs i_processor_state_regs (.*);
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles = cycles + 1;
        if (cycles == 4000) begin
            mismatches = mismatches + 1;
            results;
        end
    end
    task results;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string n, input [31:0] e, input [31:0] g);
        check_count = check_count + 1;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", n, e, g);
            mismatches = mismatches + 1;
        end
    endtask
    task rst;
        rst_n <= 1'h0;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'h1;
    endtask
    task wr(input [7:0] a, input [31:0] v, input [3:0] s);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task rd(input [7:0] a);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    task core(input [3:0] n);
        @(posedge core_clk);
        coreRegRdIdx <= n;
        @(posedge core_clk);
        #1;
    endtask
    task ovf(input e);
        @(posedge core_clk);
        integerOverflow <= 1'h1;
        floatUnderflow <= 1'h1;
        @(posedge core_clk);
        integerOverflow <= 1'h0;
        floatUnderflow <= 1'h0;
        #1;
        chk("trap", e, integerOverflowTrap);
        chk("fault", e, floatUnderflowFault);
    endtask
    task icr(input w, input [31:0] v, input ok);
        @(posedge core_clk);
        icrReq <= 1'h1;
        icrWrite <= w;
        icrIdx <= 6'h05;
        icrWrData <= v;
        @(posedge core_clk);
        icrReq <= 1'h0;
        #1;
        chk("done", ok, icrDone);
        chk("privfault", !ok, icrPrivFault);
    endtask
    task testGpr;
        for (i = 0; i < 16; i = i + 1)
            wr(8'(i * 4), 32'h80000001 | (i << 8), 4'hF);
        for (i = 0; i < 16; i = i + 1) begin
            core(4'(i));
            chk("gpr", 32'h80000001 | (i << 8), coreRegRdData);
        end
        chk("next", 32'h80000F01, nextInstrPointer);
        chk("stack", 32'h80000E01, stackTopPointer);
        chk("frame", 32'h80000D01, frameBasePointer);
        chk("arg", 32'h80000C01, argBasePointer);
        @(posedge core_clk);
        coreRegWrIdx <= 4'h3;
        coreRegWrData <= 32'h5A5A0003;
        coreRegWrEn <= 1'h1;
        @(posedge core_clk);
        coreRegWrEn <= 1'h0;
        rd(8'h0C);
        chk("corewr", 32'h5A5A0003, d);
        $display("gpr test done");
    endtask
    task testStatus;
        rd(`ADDR_STATUS_LW);
        chk("init", `STATUS_LW_RESET, d);
        icr(1'h1, 32'h12345678, 1'h1);
        icr(1'h0, 32'h0, 1'h1);
        chk("icrdata", 32'h12345678, icrRdData);
        ovf(1'h0);
        wr(`ADDR_STATUS_LW, 32'hCFDF00FF, 4'hF);
        chk("kresp", `RESP_OKAY, r);
        rd(`ADDR_STATUS_LW);
        chk("fields", 32'h4FDF00FF, d);
        chk("mode", 0, presentKernel);
        ovf(1'h1);
        icr(1'h0, 32'h0, 1'h0);
        wr(`ADDR_STATUS_LW, 32'h0, 4'hF);
        chk("uresp", `RESP_SLVERR, r);
        rd(`ADDR_STATUS_LW);
        chk("upper", 32'h4FDF0000, d);
        rst;
        rd(`ADDR_STATUS_LW);
        chk("reinit", `STATUS_LW_RESET, d);
        $display("status test done");
    endtask
    task save(input c);
        @(posedge core_clk);
        exceptionTaken <= !c;
        contextSwitch <= c;
        @(posedge core_clk);
        exceptionTaken <= 1'h0;
        contextSwitch <= 1'h0;
        #1;
        for (i = 0; i < 3 && statusSaveValid !== 1'h1; i = i + 1)
            @(posedge core_clk) #1;
        chk("saved", `STATUS_LW_RESET, statusSaveData);
        chk("savevalid", 1'h1, statusSaveValid);
        chk("dest", c, statusSaveToContext);
    endtask
    task testCore;
        @(posedge core_clk);
        ccWrData <= 4'hA;
        ccWrEn <= 1'h1;
        @(posedge core_clk);
        ccWrEn <= 1'h0;
        rd(`ADDR_STATUS_LW);
        chk("codes", 32'h041F000A, d);
        @(posedge core_clk);
        coreStatusWrData <= 32'h00000080;
        coreStatusWrEn <= 1'h1;
        @(posedge core_clk);
        coreStatusWrEn <= 1'h0;
        ovf(1'h0);
        chk("statusout", 32'h00000080, statusLongword);
        $display("core test done");
    endtask
    task testMap;
        rd(8'h80);
        chk("unmapped resp", `RESP_SLVERR, r);
        chk("unmapped data", 32'h00000000, d);
        wr(8'h41, 32'h1, 4'hF);
        chk("unaligned", `RESP_SLVERR, r);
        $display("map test done");
    endtask
    initial begin
        rst;
        testGpr;
        testStatus;
        save(1'h0);
        save(1'h1);
        $display("save test done");
        testCore;
        testMap;
        results;
    end
endmodule

// File: status_longword_reg.v
// status longword storage with fixed, inert and privileged bits
`timescale 1ns/100ps
`include "processor_state_defines.vh"
module status_longword_reg (
    input wire core_clk,
    input wire rst_n,
    input wire wrEn,
    input wire [31:0] wrData,
    input wire [31:0] wrMask,
    input wire ccEn,
    input wire [3:0] ccData,
    output wire kernelMode,
    output reg [31:0] value
);
    reg [31:0] keep;
    reg [31:0] value_next;
    assign kernelMode = value[`SL_MODE_HI:`SL_MODE_LO] == `MODE_KERNEL;
    always @* begin
        keep = wrMask;
        // upper half is privileged
        if (!kernelMode) begin
            keep = wrMask & `STATUS_LW_LOW_HALF;
        end
        value_next = value;
        if (wrEn) begin
            // compat bit and zero fields never store a one
            value_next = ((value & ~keep) | (wrData & keep)) &
                `STATUS_LW_WRITABLE;
        end
        if (ccEn) begin
            value_next[`SL_CC_HI:`SL_CC_LO] = ccData;
        end
    end
    always @(posedge core_clk) begin
        if (!rst_n) begin
            value <= `STATUS_LW_RESET;
        end else begin
            value <= value_next;
        end
    end
endmodule
